// >>> shared/smc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the SPI master block.
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

`define SMC_ADDR_W 8
`define SMC_OFF_CTRL 8'h00
`define SMC_OFF_ENABLE 8'h04
`define SMC_OFF_STATUS 8'h08
`define SMC_OFF_TXDATA 8'h0C
`define SMC_OFF_RXDATA 8'h10
`define SMC_OFF_CLKDIV 8'h14

`define SMC_CTRL_CE 6
`define SMC_CTRL_AUTO 5
`define SMC_CTRL_SRST 4
`define SMC_CTRL_SEL_HI 3
`define SMC_CTRL_SEL_LO 2
`define SMC_CTRL_DRV 1
`define SMC_CTRL_LSB 0

`define SMC_STAT_ACTIVE 2
`define SMC_STAT_RXFULL 1
`define SMC_STAT_TXEMPTY 0

`define SMC_SEL_FULL 2'h0
`define SMC_SEL_HALF 2'h1
`define SMC_DRV_RST 1'h1
`define SMC_TXEMPTY_RST 1'h1
`define SMC_DIV_RST 8'h04
`define SMC_LAST_SINGLE 3'h7
`define SMC_LAST_DUAL 3'h3

`endif

// >>> shared/smc_pkg.sv
// Types shared by the SPI master control and status block.
package smc_pkg;

	typedef struct packed {
		logic chip_select_assert;
		logic auto_clear;
		logic [1:0] input_line_select;
		logic shared_line_drive_enable;
		logic low_bit_first;
	} smc_ctrl_t;

	typedef struct packed {
		logic active;
		logic receive_holding_full;
		logic transmit_holding_empty;
	} smc_status_t;

	typedef enum logic {
		SMC_IDLE = 1'b0,
		SMC_SHIFT = 1'b1
	} smc_state_t;

endpackage

// >>> rtl/smc_top.sv
// SPI master control, status, shift engine and APB register slave.
`timescale 1ns/100ps
`include "smc_cfg.svh"

//----------------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------------

module smc_top (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [`SMC_ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Serial link
	output logic CHIP_SELECT_N_OUT,
	output logic SERIAL_CLOCK_OUT,
	output logic SERIAL_OUT_LINE_OUT,
	output logic SERIAL_OUT_LINE_OE_OUT,
	input wire logic SERIAL_IN_LINE_A_IN,
	input wire logic SERIAL_IN_LINE_B_IN,
	// Interrupt request sources
	output logic RX_REQUEST_OUT,
	output logic TX_REQUEST_OUT
);

	//------------------------------------------------------------------------
	// Functions
	//------------------------------------------------------------------------
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic a,
		input logic b, input logic lsb, input logic [1:0] sel);
		logic bit1;
		bit1 = (sel == `SMC_SEL_HALF) ? b : a;
		if (sel[1]) begin
			shift_in = lsb ? {b, a, sh[7:2]} : {sh[5:0], b, a};
		end else begin
			shift_in = lsb ? {bit1, sh[7:1]} : {sh[6:0], bit1};
		end
	endfunction

	function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
		out_bit = lsb ? sh[0] : sh[7];
	endfunction

	//------------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------------
	smc_pkg::smc_ctrl_t ctrl_reg;
	smc_pkg::smc_status_t stat;
	smc_pkg::smc_state_t state_reg;
	logic enable_reg;
	logic [7:0] div_reg;
	logic [7:0] div_cnt_reg;
	logic [7:0] tx_hold_reg;
	logic [7:0] rx_data_reg;
	logic [7:0] sh_reg;
	logic [2:0] bit_cnt_reg;
	logic pend_reg;
	logic txempty_reg;
	logic rxfull_reg;
	logic sck_reg;
	logic dir_reg;
	logic [1:0] sel_reg;
	logic cap_a_reg;
	logic cap_b_reg;
	logic a_s1_reg;
	logic a_s2_reg;
	logic b_s1_reg;
	logic b_s2_reg;
	logic pready_reg;
	logic acc;
	logic wr;
	logic clr;
	logic wr_tx;
	logic rd_rx;
	logic tick;
	logic load_now;
	logic byte_done;
	logic [1:0] eff_sel;
	logic [2:0] last_cnt;
	logic [7:0] sh_next;

	//------------------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------------------
	// One wait state lets read data come straight from a flip-flop.
	assign acc = PSEL_IN & PENABLE_IN & pready_reg;
	assign wr = acc & PWRITE_IN;
	assign clr = wr & (PADDR_IN == `SMC_OFF_CTRL) & PWDATA_IN[`SMC_CTRL_SRST];
	assign wr_tx = wr & (PADDR_IN == `SMC_OFF_TXDATA);
	assign rd_rx = acc & ~PWRITE_IN & (PADDR_IN == `SMC_OFF_RXDATA);

	//------------------------------------------------------------------------
	// Engine decode
	//------------------------------------------------------------------------
	assign eff_sel = dir_reg ? `SMC_SEL_FULL : sel_reg;
	assign last_cnt = eff_sel[1] ? `SMC_LAST_DUAL : `SMC_LAST_SINGLE;
	assign tick = enable_reg & (state_reg == smc_pkg::SMC_SHIFT) & (div_cnt_reg == div_reg);
	assign load_now = enable_reg & (state_reg == smc_pkg::SMC_IDLE) & pend_reg;
	assign byte_done = tick & sck_reg & (bit_cnt_reg == last_cnt);
	assign sh_next = shift_in(sh_reg, cap_a_reg, cap_b_reg, ctrl_reg.low_bit_first, eff_sel);
	assign stat.active = (state_reg == smc_pkg::SMC_SHIFT);
	assign stat.receive_holding_full = rxfull_reg;
	assign stat.transmit_holding_empty = txempty_reg;

	//------------------------------------------------------------------------
	// APB answer
	//------------------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pready_reg <= 1'b0;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else begin
			pready_reg <= PSEL_IN & PENABLE_IN & ~pready_reg;
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
			if (PSEL_IN & PENABLE_IN & ~pready_reg) begin
				unique case (PADDR_IN)
					`SMC_OFF_CTRL: begin
						PRDATA_OUT <= {25'h0, ctrl_reg.chip_select_assert, ctrl_reg.auto_clear,
							1'b0, ctrl_reg.input_line_select, ctrl_reg.shared_line_drive_enable,
							ctrl_reg.low_bit_first};
					end
					`SMC_OFF_ENABLE: PRDATA_OUT <= {31'h0, enable_reg};
					`SMC_OFF_STATUS: PRDATA_OUT <= {29'h0, stat};
					`SMC_OFF_TXDATA: PRDATA_OUT <= {24'h0, tx_hold_reg};
					`SMC_OFF_RXDATA: PRDATA_OUT <= {24'h0, rx_data_reg};
					`SMC_OFF_CLKDIV: PRDATA_OUT <= {24'h0, div_reg};
					default: PSLVERR_OUT <= 1'b1;
				endcase
			end
		end
	end
	assign PREADY_OUT = pready_reg;

	//------------------------------------------------------------------------
	// Control registers
	//------------------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_reg <= '{1'b0, 1'b0, 2'h0, `SMC_DRV_RST, 1'b0};
			enable_reg <= 1'b0;
			div_reg <= `SMC_DIV_RST;
			CHIP_SELECT_N_OUT <= 1'b1;
		end else if (clr) begin
			ctrl_reg <= '{1'b0, 1'b0, 2'h0, `SMC_DRV_RST, 1'b0};
			enable_reg <= 1'b0;
			div_reg <= `SMC_DIV_RST;
			CHIP_SELECT_N_OUT <= 1'b1;
		end else if (wr) begin
			if (PADDR_IN == `SMC_OFF_CTRL) begin
				ctrl_reg.chip_select_assert <= PWDATA_IN[`SMC_CTRL_CE];
				ctrl_reg.auto_clear <= PWDATA_IN[`SMC_CTRL_AUTO];
				ctrl_reg.input_line_select <= PWDATA_IN[`SMC_CTRL_SEL_HI:`SMC_CTRL_SEL_LO];
				ctrl_reg.shared_line_drive_enable <= PWDATA_IN[`SMC_CTRL_DRV];
				ctrl_reg.low_bit_first <= PWDATA_IN[`SMC_CTRL_LSB];
				CHIP_SELECT_N_OUT <= ~PWDATA_IN[`SMC_CTRL_CE];
			end
			if (PADDR_IN == `SMC_OFF_ENABLE) begin
				enable_reg <= PWDATA_IN[0];
			end
			if (PADDR_IN == `SMC_OFF_CLKDIV) begin
				div_reg <= PWDATA_IN[7:0];
			end
		end
	end

	//------------------------------------------------------------------------
	// Buffer flags
	//------------------------------------------------------------------------
	// Hardware set wins over a same-cycle software clear on both flags.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			tx_hold_reg <= 8'h00;
			rx_data_reg <= 8'h00;
			pend_reg <= 1'b0;
			txempty_reg <= `SMC_TXEMPTY_RST;
			rxfull_reg <= 1'b0;
		end else if (clr) begin
			tx_hold_reg <= 8'h00;
			rx_data_reg <= 8'h00;
			pend_reg <= 1'b0;
			txempty_reg <= `SMC_TXEMPTY_RST;
			rxfull_reg <= 1'b0;
		end else begin
			if (wr_tx) begin
				tx_hold_reg <= PWDATA_IN[7:0];
				pend_reg <= 1'b1;
			end else if (load_now) begin
				pend_reg <= 1'b0;
			end
			if (load_now) begin
				txempty_reg <= 1'b1;
			end else if (wr_tx) begin
				txempty_reg <= 1'b0;
			end else if (rd_rx & ctrl_reg.auto_clear) begin
				txempty_reg <= 1'b0;
			end
			if (byte_done) begin
				rx_data_reg <= sh_next;
				rxfull_reg <= 1'b1;
			end else if (rd_rx) begin
				rxfull_reg <= 1'b0;
			end
		end
	end
	assign RX_REQUEST_OUT = rxfull_reg;
	assign TX_REQUEST_OUT = txempty_reg;

	//------------------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			a_s1_reg <= 1'b0;
			a_s2_reg <= 1'b0;
			b_s1_reg <= 1'b0;
			b_s2_reg <= 1'b0;
		end else begin
			a_s1_reg <= SERIAL_IN_LINE_A_IN;
			a_s2_reg <= a_s1_reg;
			b_s1_reg <= SERIAL_IN_LINE_B_IN;
			b_s2_reg <= b_s1_reg;
		end
	end

	//------------------------------------------------------------------------
	// Shift engine
	//------------------------------------------------------------------------
	// Mode 0: data changes on the falling edge and is sampled on the rising edge.
	// Dropping the enable mid-byte aborts that byte; its pending byte is kept.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg <= smc_pkg::SMC_IDLE;
			sh_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			div_cnt_reg <= 8'h00;
			sck_reg <= 1'b0;
			SERIAL_OUT_LINE_OUT <= 1'b0;
			cap_a_reg <= 1'b0;
			cap_b_reg <= 1'b0;
		end else if (clr || !enable_reg) begin
			state_reg <= smc_pkg::SMC_IDLE;
			bit_cnt_reg <= 3'h0;
			div_cnt_reg <= 8'h00;
			sck_reg <= 1'b0;
			SERIAL_OUT_LINE_OUT <= 1'b0;
			if (clr) begin
				sh_reg <= 8'h00;
			end
		end else begin
			unique case (state_reg)
				smc_pkg::SMC_IDLE: begin
					if (load_now) begin
						sh_reg <= tx_hold_reg;
						SERIAL_OUT_LINE_OUT <= out_bit(tx_hold_reg, ctrl_reg.low_bit_first);
						bit_cnt_reg <= 3'h0;
						div_cnt_reg <= 8'h00;
						state_reg <= smc_pkg::SMC_SHIFT;
					end
				end
				smc_pkg::SMC_SHIFT: begin
					div_cnt_reg <= tick ? 8'h00 : div_cnt_reg + 8'h01;
					if (tick && !sck_reg) begin
						sck_reg <= 1'b1;
						cap_a_reg <= a_s2_reg;
						cap_b_reg <= b_s2_reg;
					end else if (tick) begin
						sck_reg <= 1'b0;
						sh_reg <= sh_next;
						SERIAL_OUT_LINE_OUT <= out_bit(sh_next, ctrl_reg.low_bit_first);
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (byte_done) begin
							state_reg <= smc_pkg::SMC_IDLE;
						end
					end
				end
			endcase
		end
	end
	assign SERIAL_CLOCK_OUT = sck_reg;

	//------------------------------------------------------------------------
	// Latched link mode
	//------------------------------------------------------------------------
	// Direction and input choice are copied only while no byte is shifting, so a
	// control write in mid-byte cannot turn the out line round or swap the inputs.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			dir_reg <= `SMC_DRV_RST;
			sel_reg <= `SMC_SEL_FULL;
		end else if (clr) begin
			dir_reg <= `SMC_DRV_RST;
			sel_reg <= `SMC_SEL_FULL;
		end else if (!enable_reg || state_reg == smc_pkg::SMC_IDLE) begin
			dir_reg <= ctrl_reg.shared_line_drive_enable;
			sel_reg <= ctrl_reg.input_line_select;
		end
	end

	//------------------------------------------------------------------------
	// Out line direction
	//------------------------------------------------------------------------
	// Full duplex drives whenever enabled; half duplex and dual follow the latched direction.
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			SERIAL_OUT_LINE_OE_OUT <= 1'b0;
		end else begin
			SERIAL_OUT_LINE_OE_OUT <= enable_reg & ~clr &
				((sel_reg == `SMC_SEL_FULL) | dir_reg);
		end
	end

endmodule

// >>> verif/smc_monitor.sv
// Port-level checks of the SPI master control and status block.
`timescale 1ns/100ps
`include "smc_cfg.svh"
module smc_monitor (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [`SMC_ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PREADY_OUT,
	input wire logic CHIP_SELECT_N_OUT,
	input wire logic SERIAL_CLOCK_OUT,
	input wire logic SERIAL_OUT_LINE_OUT,
	input wire logic SERIAL_OUT_LINE_OE_OUT,
	input wire logic RX_REQUEST_OUT,
	input wire logic TX_REQUEST_OUT
);
	logic auto_reg;
	wire acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	wire wr_ctrl = acc && PWRITE_IN && PADDR_IN == `SMC_OFF_CTRL;
	wire wr_en = acc && PWRITE_IN && PADDR_IN == `SMC_OFF_ENABLE;
	// A byte ending at the same edge may set the rx full flag again, so such reads are skipped.
	wire rd_rx = acc && !PWRITE_IN && PADDR_IN == `SMC_OFF_RXDATA && !SERIAL_CLOCK_OUT;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			auto_reg <= 1'b0;
		end else if (wr_ctrl) begin
			auto_reg <= PWDATA_IN[5] && !PWDATA_IN[4];
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence s_quiet;
		!SERIAL_CLOCK_OUT && !SERIAL_OUT_LINE_OUT && !SERIAL_OUT_LINE_OE_OUT;
	endsequence
	AST_CS_LEVEL: assert property (wr_ctrl && !PWDATA_IN[4] |-> ##2
		CHIP_SELECT_N_OUT == !$past(PWDATA_IN[6], 2)) else $error("chip select wrong");
	AST_SOFT_RESET: assert property (wr_ctrl && PWDATA_IN[4] |-> ##2
		CHIP_SELECT_N_OUT && TX_REQUEST_OUT && !RX_REQUEST_OUT) else $error("soft reset");
	AST_RX_CLEAR: assert property (rd_rx |=> !RX_REQUEST_OUT)
		else $error("rx full kept");
	AST_AUTO_CLEAR: assert property (rd_rx && auto_reg |=> !TX_REQUEST_OUT)
		else $error("tx empty kept");
	AST_NO_AUTO: assert property (rd_rx && !auto_reg && TX_REQUEST_OUT |=> TX_REQUEST_OUT)
		else $error("tx empty cleared");
	AST_QUIET_OFF: assert property (wr_en && !PWDATA_IN[0] |-> ##3 s_quiet [*4])
		else $error("lines not idle");
	AST_DIR_LOW: assert property ($changed(SERIAL_OUT_LINE_OE_OUT) |-> !SERIAL_CLOCK_OUT)
		else $error("direction changed mid pulse");
	AST_RESET_VAL: assert property ($rose(RST_N_IN) |-> TX_REQUEST_OUT &&
		!RX_REQUEST_OUT && CHIP_SELECT_N_OUT && !PREADY_OUT) else $error("reset values");
endmodule
bind smc_top smc_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .CHIP_SELECT_N_OUT(CHIP_SELECT_N_OUT),
	.SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT), .SERIAL_OUT_LINE_OUT(SERIAL_OUT_LINE_OUT),
	.SERIAL_OUT_LINE_OE_OUT(SERIAL_OUT_LINE_OE_OUT), .RX_REQUEST_OUT(RX_REQUEST_OUT),
	.TX_REQUEST_OUT(TX_REQUEST_OUT));

// >>> verif/smc_slave_model.sv
// Serial slave that answers a fixed byte most significant bit first and records its input.
`timescale 1ns/100ps
module smc_slave_model #(
	parameter logic [7:0] REPLY = 8'hC3
) (
	input wire logic cs_n_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	output logic line_a_out,
	output logic line_b_out,
	output logic [7:0] got_out
);
	int idx = 7;
	initial begin
		line_a_out = 1'b0;
		got_out = 8'h00;
	end
	// Line b carries the inverse so a wrong input choice shows in the received byte.
	assign line_b_out = ~line_a_out;
	always @(negedge cs_n_in) begin
		idx = 7;
		line_a_out = REPLY[7];
	end
	// Deselected, the line no longer holds the last bit.
	always @(posedge cs_n_in) line_a_out = ~line_a_out;
	always @(posedge sck_in) got_out = {got_out[6:0], mosi_in};
	always @(negedge sck_in) begin
		idx = (idx == 0) ? 7 : idx - 1;
		line_a_out = cs_n_in ? ~line_a_out : REPLY[idx];
	end
endmodule

// >>> verif/smc_top_test.sv
// Self-checking bench for the SPI master control and status block.
`timescale 1ns/100ps
`include "smc_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module smc_top_test;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, perr, err, cs_n, sck, sdo, oe, rxq, txq, in_a, in_b;
	logic [7:0] got;
	int fail_count = 0, n_tests = 0;
	smc_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(perr), .CHIP_SELECT_N_OUT(cs_n),
		.SERIAL_CLOCK_OUT(sck), .SERIAL_OUT_LINE_OUT(sdo), .SERIAL_OUT_LINE_OE_OUT(oe),
		.SERIAL_IN_LINE_A_IN(in_a), .SERIAL_IN_LINE_B_IN(in_b), .RX_REQUEST_OUT(rxq),
		.TX_REQUEST_OUT(txq));
	smc_slave_model peer (.cs_n_in(cs_n), .sck_in(sck), .mosi_in(oe ? sdo : 1'bz),
		.line_a_out(in_a), .line_b_out(in_b), .got_out(got));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fail_count++;
		rdata = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdata, e)
	endtask
	task automatic wait_rx;
		int n = 0;
		while (rxq !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) fail_count++;
	endtask
	task automatic tally_and_finish;
		$display("Mismatches %0d of %0d checks", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#100us;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(`SMC_OFF_CTRL, 32'h2);
		rd(`SMC_OFF_STATUS, 32'h1);
		`CHK(txq, 1'b1)
		rd(8'h18, 32'h0);
		`CHK(err, 1'b1)
		wr(`SMC_OFF_ENABLE, 32'h1);
		wr(`SMC_OFF_CLKDIV, 32'h7);
		wr(`SMC_OFF_CTRL, 32'hFFFF_FFC0);
		rd(`SMC_OFF_CTRL, 32'h40);
		`CHK(cs_n, 1'b0)
		wr(`SMC_OFF_TXDATA, 32'h5A);
		rd(`SMC_OFF_STATUS, 32'h5);
		wait_rx();
		`CHK(got, 8'h5A)
		rd(`SMC_OFF_RXDATA, 32'hC3);
		rd(`SMC_OFF_STATUS, 32'h1);
		wr(`SMC_OFF_CTRL, 32'h41);
		wr(`SMC_OFF_TXDATA, 32'h35);
		wait_rx();
		`CHK(got, 8'hAC)
		rd(`SMC_OFF_RXDATA, 32'hC3);
		wr(`SMC_OFF_CTRL, 32'h60);
		wr(`SMC_OFF_TXDATA, 32'h11);
		wr(`SMC_OFF_TXDATA, 32'h22);
		rd(`SMC_OFF_STATUS, 32'h4);
		wait_rx();
		rd(`SMC_OFF_RXDATA, 32'hC3);
		rd(`SMC_OFF_STATUS, 32'h4);
		wait_rx();
		`CHK(got, 8'h22)
		rd(`SMC_OFF_RXDATA, 32'hC3);
		wr(`SMC_OFF_CTRL, 32'h44);
		wr(`SMC_OFF_TXDATA, 32'h00);
		wait_rx();
		`CHK(oe, 1'b0)
		rd(`SMC_OFF_RXDATA, 32'h3C);
		wr(`SMC_OFF_CTRL, 32'h48);
		wr(`SMC_OFF_TXDATA, 32'h00);
		wait_rx();
		rd(`SMC_OFF_RXDATA, 32'h5A);
		wr(`SMC_OFF_TXDATA, 32'h0F);
		wr(`SMC_OFF_CTRL, 32'h40);
		repeat (3) @(posedge clk);
		`CHK(oe, 1'b0)
		wr(`SMC_OFF_ENABLE, 32'h0);
		repeat (3) @(posedge clk);
		`CHK(sck, 1'b0)
		wr(`SMC_OFF_CTRL, 32'h50);
		rd(`SMC_OFF_CTRL, 32'h2);
		rd(`SMC_OFF_STATUS, 32'h1);
		rd(`SMC_OFF_ENABLE, 32'h0);
		`CHK(cs_n, 1'b1)
		tally_and_finish();
	end
endmodule
